// [bench/fswe_array_model.sv]
module fswe_array_model
   import fswe_pkg::*;
#(
   parameter logic [DATA_W-1:0] MAKER_ID   = 8'h3c, // Arbitrary value
   parameter logic [DATA_W-1:0] PRODUCT_ID = 8'h5a, // Arbitrary value
   parameter int                ABORT_NS   = 400,
   parameter bit                VCC_OK     = 1'b1
)
(
   input  wire logic              chip_sel_n,
   input  wire logic              out_en_n,
   input  wire logic              wr_strobe_n,
   input  wire logic [ADDR_W-1:0] addr_out,
   input  wire logic              id_mode_address_pin,
   input  wire logic              prog_supply_hi,
   input  wire logic [DATA_W-1:0] data_out,
   input  wire logic              data_oe_n,
   output logic [DATA_W-1:0]      data_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [DATA_W-1:0] mem [0:SECTOR_COUNT*SECTOR_BYTES-1];
   logic [ADDR_W-1:0] lat_a;
   logic [DATA_W-1:0] last_q = 8'h00;
   logic [6:0]        sect;
   logic              pend = 1'b0;
   logic              chip_arm = 1'b0;
   realtime           t_fall;
   event              start_ev;
   wire we = !chip_sel_n && out_en_n && !wr_strobe_n;
   wire rd = !chip_sel_n && !out_en_n && wr_strobe_n;

   // Read or identity byte, else inverse of last value
   assign data_in = rd ? (id_mode_address_pin ? (addr_out[0] ? PRODUCT_ID : MAKER_ID)
                                              : mem[addr_out]) : ~last_q;
   always @(data_in) if (rd) last_q = data_in;

   // Address on the later falling edge
   always @(posedge we) begin
      lat_a = addr_out;
      t_fall = $realtime;
   end
   // Data on the earlier rising edge, short pulses dropped
   always @(negedge we) begin
      if ($realtime - t_fall >= 20.0 && !data_oe_n && VCC_OK) begin
         if (!prog_supply_hi) chip_arm = 1'b1;
         else if (data_out == ERASED_BYTE && chip_arm) begin
            foreach (mem[i]) mem[i] = ERASED_BYTE;
            chip_arm = 1'b0;
         end else if (data_out == ERASED_BYTE) begin
            sect = lat_a[15:9];
            pend = 1'b1;
            -> start_ev;
         end else if (pend) pend = 1'b0;
         else mem[lat_a] = mem[lat_a] & data_out;
      end
   end
   // Sector erase after the abort delay
   always @(start_ev) begin
      #(ABORT_NS);
      if (pend) for (int i = 0; i < SECTOR_BYTES; i++) mem[{sect, 9'h000} + i] = ERASED_BYTE;
      pend = 1'b0;
   end
endmodule

// [bench/fswe_host_assertions.sv]
module fswe_host_assertions
   import fswe_pkg::*;
(
   input wire logic              clk,
   input wire logic              rst,
   input wire logic              chip_sel_n,
   input wire logic              out_en_n,
   input wire logic              wr_strobe_n,
   input wire logic [ADDR_W-1:0] addr_out,
   input wire logic              id_mode_address_pin,
   input wire logic [DATA_W-1:0] data_out,
   input wire logic              data_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Strobe and output enable only inside a selected frame
   chk_strobe_sel: assert property (!wr_strobe_n |-> !chip_sel_n)
      else $error("strobe low without select");
   chk_oe_sel: assert property (!out_en_n |-> !chip_sel_n)
      else $error("output enable low without select");
   chk_write_state: assert property (!wr_strobe_n |-> out_en_n && !data_oe_n)
      else $error("write strobe with wrong control state");
   chk_bus_no_fight: assert property (!out_en_n |-> data_oe_n)
      else $error("host drives data during read");
   chk_strobe_width: assert property ($fell(wr_strobe_n) |-> !wr_strobe_n [*8])
      else $error("write strobe pulse too short");
   chk_read_hold: assert property ($fell(out_en_n) |-> !out_en_n [*8])
      else $error("read pulse too short");
   chk_latch_stable: assert property (!wr_strobe_n && $past(wr_strobe_n) == 1'b0
      |-> $stable(addr_out) && $stable(data_out))
      else $error("address or data moved under strobe");
   chk_id_addr: assert property (id_mode_address_pin && !chip_sel_n
      |-> addr_out[ADDR_W-1:1] == '0)
      else $error("identity read with upper address bits set");
   chk_id_no_write: assert property (id_mode_address_pin |-> wr_strobe_n)
      else $error("write strobe during identity read");
endmodule

bind fswe_host fswe_host_assertions u_chk (.clk, .rst, .chip_sel_n, .out_en_n, .wr_strobe_n,
   .addr_out, .id_mode_address_pin, .data_out, .data_oe_n);

// [bench/fswe_port_tb.sv]
module fswe_host_tb import fswe_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] MAKER_ID   = 8'h3c; // Arbitrary value
   localparam logic [7:0] PRODUCT_ID = 8'h5a; // Arbitrary value
   logic clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0;
   fswe_cmd_t cmd_op = FSWE_CMD_READ;
   logic [ADDR_W-1:0] cmd_addr = ADDR_ZERO, cmd_last = ADDR_ZERO, src_addr, addr_out, a, r;
   logic [DATA_W-1:0] src_data = 8'h00, key = 8'h00, rsp_data, data_out, data_in;
   logic cmd_ready, src_req, rsp_valid, rsp_fail, chip_sel_n, out_en_n, wr_strobe_n;
   logic id_mode_address_pin, prog_supply_hi, data_oe_n, f;
   logic [6:0] sec;
   int err_count = 0, n_tests = 0, i;

   fswe_host #(.WC_CYC(20), .VPH_CYC(20), .ERASE_CYC(50), .ABORT_CYC(30)) DUT (.clk, .rst,
      .cmd_valid, .cmd_op, .cmd_addr, .cmd_last, .cmd_ready, .src_req, .src_addr, .src_data,
      .rsp_valid, .rsp_data, .rsp_fail, .chip_sel_n, .out_en_n, .wr_strobe_n, .addr_out,
      .id_mode_address_pin, .prog_supply_hi, .data_out, .data_oe_n, .data_in);
   fswe_array_model #(.MAKER_ID(MAKER_ID), .PRODUCT_ID(PRODUCT_ID)) MDL (.chip_sel_n,
      .out_en_n, .wr_strobe_n, .addr_out, .id_mode_address_pin, .prog_supply_hi, .data_out,
      .data_oe_n, .data_in);

   always #10 clk = ~clk;
   // Source bytes follow the requested address
   always @(negedge clk) src_data <= pat(src_addr);

   function automatic logic [7:0] pat(input logic [15:0] x);
      return x[7:0] ^ key;
   endfunction
   function automatic logic [7:0] fill(input logic [15:0] x);
      return x[7:0] ^ x[15:8] ^ 8'h96;
   endfunction

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
         err_count++;
      end
   endtask
   // One command, waits for its response
   task automatic run(input fswe_cmd_t op, input logic [15:0] s, input logic [15:0] l);
      int k;
      for (k = 0; k < 1000 && cmd_ready !== 1'b1; k++) @(negedge clk);
      cmd_op = op;
      cmd_addr = s;
      cmd_last = l;
      cmd_valid = 1'b1;
      @(negedge clk);
      cmd_valid = 1'b0;
      for (k = 0; k < 60000 && rsp_valid !== 1'b1; k++) @(negedge clk);
      if (rsp_valid !== 1'b1) err_count++;
   endtask
   task automatic rd(input logic [15:0] x, input logic [7:0] exp);
      run(FSWE_CMD_READ, x, x);
      check(rsp_data, exp);
   endtask
   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // Watchdog
   initial begin
      #1500000;
      err_count++;
      report_and_stop;
   end
   // Main sequence
   initial begin
      for (i = 0; i < 65536; i++) MDL.mem[i] = fill(16'(i));
      repeat (5) @(negedge clk);
      rst = 1'b0;
      void'($urandom(36527));
      for (i = 0; i < 2; i++) begin
         run(FSWE_CMD_ID, 16'(i), 16'(i));
         check(rsp_data, i ? PRODUCT_ID : MAKER_ID);
      end
      sec = 7'($urandom_range(127));
      a = {sec, 9'h000};
      run(FSWE_CMD_SECTOR, a, a);
      check({7'h00, rsp_fail}, 8'h00);
      check({7'h00, prog_supply_hi}, 8'h00);
      rd(a, ERASED_BYTE);
      rd(a + SECT_OFS_LAST, ERASED_BYTE);
      r = (sec == 7'h7f) ? a - 16'h0001 : a + 16'h0200;
      rd(r, fill(r));
      a = a + 16'($urandom_range(500));
      key = 8'($urandom);
      run(FSWE_CMD_PROG, a, a + 16'h0003);
      check({7'h00, rsp_fail}, 8'h00);
      for (i = 0; i < 4; i++) rd(a + 16'(i), pat(a + 16'(i)));
      key = ~key;
      f = 1'b0;
      for (i = 0; i < 4; i++) if (pat(a + 16'(i)) != 8'h00) f = 1'b1;
      run(FSWE_CMD_PROG, a, a + 16'h0003);
      check({7'h00, rsp_fail}, {7'h00, f});
      for (i = 0; i < 4; i++) rd(a + 16'(i), 8'h00);
      // Sector rewrite: erase whole sector, then program four new bytes at a
      key = 8'($urandom);
      run(FSWE_CMD_SECTOR, a, a);
      run(FSWE_CMD_PROG, a, a + 16'h0003);
      check({7'h00, rsp_fail}, 8'h00);
      for (i = 0; i < 4; i++) rd(a + 16'(i), pat(a + 16'(i)));
      for (i = 0; i < 8; i++) begin
         r = 16'($urandom);
         if (r[15:9] == sec) r[15] = ~r[15];
         rd(r, fill(r));
      end
      report_and_stop;
   end
endmodule

// [verilog/fswe_bus_cycle.sv]
module fswe_bus_cycle
   import fswe_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   fswe_cyc_if.phy                cyc,
   output logic                   chip_sel_n,
   output logic                   out_en_n,
   output logic                   wr_strobe_n,
   output logic [ADDR_W-1:0]      addr_out,
   output logic                   id_mode_address_pin,
   output logic [DATA_W-1:0]      data_out,
   output logic                   data_oe_n,
   input  wire logic [DATA_W-1:0] data_in
);
   typedef enum logic [3:0] {
      FSWE_P_IDLE  = 4'b0001,
      FSWE_P_SETUP = 4'b0010,
      FSWE_P_PULSE = 4'b0100,
      FSWE_P_HOLD  = 4'b1000
   } fswe_phase_t;

   fswe_phase_t phase_q;
   logic [7:0]  cnt_q;
   fswe_cyc_t   kind_q;

   // Phase sequencer with fixed per-phase cycle counts
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_q <= FSWE_P_IDLE;
         cnt_q   <= 8'h00;
         kind_q  <= FSWE_CYC_READ;
      end else begin
         case (phase_q)
            FSWE_P_IDLE: begin
               cnt_q <= 8'h00;
               if (cyc.start) begin
                  kind_q  <= cyc.kind;
                  phase_q <= FSWE_P_SETUP;
               end
            end
            FSWE_P_SETUP: begin
               cnt_q <= cnt_q + 8'h01;
               if (cnt_q == 8'(SETUP_CYC - 1)) begin
                  cnt_q   <= 8'h00;
                  phase_q <= FSWE_P_PULSE;
               end
            end
            FSWE_P_PULSE: begin
               cnt_q <= cnt_q + 8'h01;
               // Strobe kept low well past the noise filter width
               if (cnt_q == 8'((kind_q == FSWE_CYC_WRITE ? WP_CYC : READ_CYC) - 1)) begin
                  cnt_q   <= 8'h00;
                  phase_q <= FSWE_P_HOLD;
               end
            end
            FSWE_P_HOLD: begin
               cnt_q <= cnt_q + 8'h01;
               if (cnt_q == 8'(HOLD_CYC - 1)) begin
                  phase_q <= FSWE_P_IDLE;
               end
            end
            default: phase_q <= FSWE_P_IDLE;
         endcase
      end
   end

   // Pin drive: address and chip select before strobe, data held past it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         chip_sel_n          <= 1'b1;
         out_en_n            <= 1'b1;
         wr_strobe_n         <= 1'b1;
         addr_out            <= ADDR_ZERO;
         id_mode_address_pin <= 1'b0;
         data_out            <= ERASED_BYTE;
         data_oe_n           <= 1'b1;
      end else begin
         case (phase_q)
            FSWE_P_IDLE: begin
               wr_strobe_n <= 1'b1;
               out_en_n    <= 1'b1;
               data_oe_n   <= 1'b1;
               chip_sel_n  <= 1'b1;
               if (cyc.start) begin
                  chip_sel_n          <= 1'b0;
                  addr_out            <= cyc.addr;
                  data_out            <= cyc.wdata;
                  id_mode_address_pin <= (cyc.kind == FSWE_CYC_ID);
                  data_oe_n           <= (cyc.kind != FSWE_CYC_WRITE);
               end
            end
            FSWE_P_SETUP: begin
               if (cnt_q == 8'(SETUP_CYC - 1)) begin
                  // Write: output enable high, strobe low; read: reverse
                  wr_strobe_n <= (kind_q != FSWE_CYC_WRITE);
                  out_en_n    <= (kind_q == FSWE_CYC_WRITE);
               end
            end
            FSWE_P_PULSE: begin
               if (phase_q == FSWE_P_PULSE &&
                   cnt_q == 8'((kind_q == FSWE_CYC_WRITE ? WP_CYC : READ_CYC) - 1)) begin
                  wr_strobe_n <= 1'b1;
                  out_en_n    <= 1'b1;
               end
            end
            FSWE_P_HOLD: begin
               if (cnt_q == 8'(HOLD_CYC - 1)) begin
                  chip_sel_n          <= 1'b1;
                  data_oe_n           <= 1'b1;
                  id_mode_address_pin <= 1'b0;
               end
            end
            default: chip_sel_n <= 1'b1;
         endcase
      end
   end

   // Read data sampled at end of access, done pulse at end of hold
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cyc.rdata <= ERASED_BYTE;
         cyc.done  <= 1'b0;
      end else begin
         cyc.done <= (phase_q == FSWE_P_HOLD) && (cnt_q == 8'(HOLD_CYC - 1));
         if (phase_q == FSWE_P_PULSE && kind_q != FSWE_CYC_WRITE &&
             cnt_q == 8'(READ_CYC - 1)) begin
            cyc.rdata <= data_in;
         end
      end
   end
endmodule

// [verilog/fswe_cyc_if.sv]
interface fswe_cyc_if;
   import fswe_pkg::*;
   logic                start;
   fswe_cyc_t           kind;
   logic [ADDR_W-1:0]   addr;
   logic [DATA_W-1:0]   wdata;
   logic                done;
   logic [DATA_W-1:0]   rdata;
   modport seq (output start, output kind, output addr, output wdata,
                input done, input rdata);
   modport phy (input start, input kind, input addr, input wdata,
                output done, output rdata);
endinterface

// [verilog/fswe_host.sv]
module fswe_host
   import fswe_pkg::*;
#(
   parameter int WC_CYC    = (T_WC_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
   parameter int VPH_CYC   = (T_VPH_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
   parameter int ERASE_CYC = T_ERASE_US / 1000 * (1000 / CLK_PERIOD_NS),
   parameter int ABORT_CYC = (T_ABORT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
)
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              cmd_valid,
   input  wire fswe_cmd_t         cmd_op,
   input  wire logic [ADDR_W-1:0] cmd_addr,
   input  wire logic [ADDR_W-1:0] cmd_last,
   output logic                   cmd_ready,
   output logic                   src_req,
   output logic [ADDR_W-1:0]      src_addr,
   input  wire logic [DATA_W-1:0] src_data,
   output logic                   rsp_valid,
   output logic [DATA_W-1:0]      rsp_data,
   output logic                   rsp_fail,
   output logic                   chip_sel_n,
   output logic                   out_en_n,
   output logic                   wr_strobe_n,
   output logic [ADDR_W-1:0]      addr_out,
   output logic                   id_mode_address_pin,
   output logic                   prog_supply_hi,
   output logic [DATA_W-1:0]      data_out,
   output logic                   data_oe_n,
   input  wire logic [DATA_W-1:0] data_in
);
   typedef enum logic [9:0] {
      FSWE_S_IDLE   = 10'b0000000001,
      FSWE_S_VPS    = 10'b0000000010,
      FSWE_S_FETCH  = 10'b0000000100,
      FSWE_S_CYCLE  = 10'b0000001000,
      FSWE_S_WAIT   = 10'b0000010000,
      FSWE_S_VERIFY = 10'b0000100000,
      FSWE_S_VPH    = 10'b0001000000,
      FSWE_S_RDONE  = 10'b0010000000,
      FSWE_S_RESP   = 10'b0100000000,
      FSWE_S_ECHK   = 10'b1000000000
   } fswe_state_t;

   fswe_cyc_if cyc ();

   fswe_state_t       st_q;
   fswe_cmd_t         op_q;
   logic [ADDR_W-1:0] addr_q;
   logic [ADDR_W-1:0] last_q;
   logic [4:0]        pass_q;
   logic              fill_q;
   logic              bad_q;
   logic [TMR_W-1:0]  tmr_q;
   logic              start_q;
   fswe_cyc_t         kind_q;
   logic [DATA_W-1:0] wdata_q;
   logic [ADDR_W-1:0] first_q;

   // Writing ones leaves a bit unchanged, so skip erased bytes
   function automatic logic needs_write(input logic [DATA_W-1:0] b);
      return b != ERASED_BYTE;
   endfunction

   // Sector base from any address inside it
   function automatic logic [ADDR_W-1:0] sector_base(input logic [ADDR_W-1:0] a);
      return a & ~SECT_OFS_LAST;
   endfunction

   assign cyc.start = start_q;
   assign cyc.kind  = kind_q;
   assign cyc.addr  = addr_q;
   assign cyc.wdata = wdata_q;

   fswe_bus_cycle u_cyc (
      .clk                 (clk),
      .rst                 (rst),
      .cyc                 (cyc),
      .chip_sel_n          (chip_sel_n),
      .out_en_n            (out_en_n),
      .wr_strobe_n         (wr_strobe_n),
      .addr_out            (addr_out),
      .id_mode_address_pin (id_mode_address_pin),
      .data_out            (data_out),
      .data_oe_n           (data_oe_n),
      .data_in             (data_in)
   );

   // Operation sequencer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q           <= FSWE_S_IDLE;
         op_q           <= FSWE_CMD_READ;
         addr_q         <= ADDR_ZERO;
         last_q         <= ADDR_ZERO;
         pass_q         <= PASS_ZERO;
         fill_q         <= 1'b0;
         bad_q          <= 1'b0;
         tmr_q          <= '0;
         start_q        <= 1'b0;
         kind_q         <= FSWE_CYC_READ;
         wdata_q        <= ERASED_BYTE;
         cmd_ready      <= 1'b1;
         src_req        <= 1'b0;
         src_addr       <= ADDR_ZERO;
         rsp_valid      <= 1'b0;
         rsp_data       <= ERASED_BYTE;
         rsp_fail       <= 1'b0;
         prog_supply_hi <= 1'b0;
      end else begin
         start_q   <= 1'b0;
         src_req   <= 1'b0;
         rsp_valid <= 1'b0;
         case (st_q)
            FSWE_S_IDLE: begin
               if (cmd_valid) begin
                  cmd_ready <= 1'b0;
                  op_q      <= cmd_op;
                  pass_q    <= PASS_ZERO;
                  fill_q    <= 1'b0;
                  bad_q     <= 1'b0;
                  tmr_q     <= '0;
                  last_q    <= cmd_last;
                  case (cmd_op)
                     FSWE_CMD_SECTOR: begin
                        // Whole-sector erase, first step of any sector rewrite
                        addr_q         <= sector_base(cmd_addr);
                        last_q         <= sector_base(cmd_addr) | SECT_OFS_LAST;
                        prog_supply_hi <= 1'b1;
                        st_q           <= FSWE_S_VPS;
                     end
                     FSWE_CMD_CHIP: begin
                        // Arm with a write at logic-level supply first
                        addr_q  <= ADDR_ZERO;
                        last_q  <= ADDR_LAST;
                        wdata_q <= ERASED_BYTE;
                        kind_q  <= FSWE_CYC_WRITE;
                        start_q <= 1'b1;
                        st_q    <= FSWE_S_CYCLE;
                     end
                     FSWE_CMD_PROG: begin
                        addr_q         <= cmd_addr;
                        prog_supply_hi <= 1'b1;
                        st_q           <= FSWE_S_VPS;
                     end
                     default: begin
                        // Plain read or identity read, supply left low
                        addr_q  <= (cmd_op == FSWE_CMD_ID) ? {15'h0000, cmd_addr[0]}
                                                           : cmd_addr;
                        kind_q  <= (cmd_op == FSWE_CMD_ID) ? FSWE_CYC_ID : FSWE_CYC_READ;
                        start_q <= 1'b1;
                        st_q    <= FSWE_S_RDONE;
                     end
                  endcase
               end
            end
            FSWE_S_VPS: begin
               tmr_q <= tmr_q + 1'b1;
               if (tmr_q == TMR_W'(VPS_CYC - 1)) begin
                  tmr_q <= '0;
                  if (op_q == FSWE_CMD_PROG) begin
                     src_req  <= 1'b1;
                     src_addr <= addr_q;
                     st_q     <= FSWE_S_FETCH;
                  end else begin
                     // Erase trigger: all-ones write, then no write in abort window
                     wdata_q <= ERASED_BYTE;
                     kind_q  <= FSWE_CYC_WRITE;
                     start_q <= 1'b1;
                     st_q    <= FSWE_S_CYCLE;
                  end
               end
            end
            FSWE_S_FETCH: begin
               // Source answers one cycle after request
               wdata_q <= src_data;
               if (needs_write(src_data) && !(fill_q && !bad_q)) begin
                  kind_q  <= FSWE_CYC_WRITE;
                  start_q <= 1'b1;
                  st_q    <= FSWE_S_CYCLE;
               end else begin
                  st_q <= FSWE_S_WAIT;
                  tmr_q <= TMR_W'(WC_CYC - 1);
               end
            end
            FSWE_S_CYCLE: begin
               // Expected byte arrives one cycle after its request
               if (src_req) begin
                  wdata_q <= src_data;
               end
               if (cyc.done) begin
                  tmr_q <= '0;
                  if (op_q == FSWE_CMD_CHIP && !prog_supply_hi) begin
                     // Arming write done, raise supply for the erase write
                     prog_supply_hi <= 1'b1;
                     st_q           <= FSWE_S_VPS;
                  end else begin
                     st_q <= (kind_q == FSWE_CYC_WRITE) ? FSWE_S_WAIT : FSWE_S_VERIFY;
                  end
               end
            end
            FSWE_S_WAIT: begin
               tmr_q <= tmr_q + 1'b1;
               if (op_q != FSWE_CMD_PROG) begin
                  // Abort window plus erase time, then verify ones
                  if (tmr_q == TMR_W'(ABORT_CYC + ERASE_CYC - 1)) begin
                     tmr_q   <= '0;
                     kind_q  <= FSWE_CYC_READ;
                     start_q <= 1'b1;
                     st_q    <= FSWE_S_CYCLE;
                  end
               end else if (tmr_q == TMR_W'(WC_CYC - 1)) begin
                  tmr_q <= '0;
                  if (addr_q != last_q) begin
                     addr_q   <= addr_q + 1'b1;
                     src_req  <= 1'b1;
                     src_addr <= addr_q + 1'b1;
                     st_q     <= FSWE_S_FETCH;
                  end else if (!fill_q && pass_q != WRITE_PASSES - 5'h01) begin
                     pass_q   <= pass_q + 5'h01;
                     addr_q   <= first_q;
                     src_req  <= 1'b1;
                     src_addr <= first_q;
                     st_q     <= FSWE_S_FETCH;
                  end else begin
                     // Verify pass follows write passes and each fill-in pass
                     fill_q   <= 1'b1;
                     bad_q    <= 1'b0;
                     addr_q   <= first_q;
                     src_req  <= 1'b1;
                     src_addr <= first_q;
                     kind_q  <= FSWE_CYC_READ;
                     start_q <= 1'b1;
                     st_q    <= FSWE_S_CYCLE;
                  end
               end
            end
            FSWE_S_VERIFY: begin
               // Erase expects all ones, program the fetched byte
               if (cyc.rdata != ((op_q != FSWE_CMD_PROG) ? ERASED_BYTE : wdata_q)) begin
                  bad_q <= 1'b1;
               end
               st_q <= FSWE_S_ECHK;
            end
            FSWE_S_ECHK: begin
               if (op_q == FSWE_CMD_PROG) begin
                  // Fetch expected byte of the next address
                  src_req  <= 1'b1;
                  src_addr <= addr_q + 1'b1;
                  if (addr_q != last_q) begin
                     addr_q <= addr_q + 1'b1;
                     kind_q <= FSWE_CYC_READ;
                     start_q <= 1'b1;
                     st_q   <= FSWE_S_CYCLE;
                  end else if (bad_q && pass_q != WRITE_PASSES + WRITE_PASSES) begin
                     pass_q   <= pass_q + 5'h01;
                     addr_q   <= first_q;
                     src_addr <= first_q;
                     st_q     <= FSWE_S_FETCH;
                  end else begin
                     st_q <= FSWE_S_VPH;
                  end
               end else if (bad_q || addr_q == last_q) begin
                  // Failed cell restarts erase cycle below the pass limit; clean sweep or limit finishes
                  if (bad_q && pass_q != WRITE_PASSES + WRITE_PASSES) begin
                     pass_q  <= pass_q + 5'h01;
                     bad_q   <= 1'b0;
                     // Chip erase is re-armed at logic-level supply
                     if (op_q == FSWE_CMD_CHIP) begin
                        prog_supply_hi <= 1'b0;
                     end
                     addr_q  <= first_q;
                     kind_q  <= FSWE_CYC_WRITE;
                     start_q <= 1'b1;
                     st_q    <= FSWE_S_CYCLE;
                  end else begin
                     st_q <= FSWE_S_VPH;
                  end
               end else begin
                  addr_q  <= addr_q + 1'b1;
                  kind_q  <= FSWE_CYC_READ;
                  start_q <= 1'b1;
                  st_q    <= FSWE_S_CYCLE;
               end
            end
            FSWE_S_VPH: begin
               tmr_q <= tmr_q + 1'b1;
               if (tmr_q == TMR_W'(VPH_CYC - 1)) begin
                  prog_supply_hi <= 1'b0;
                  st_q           <= FSWE_S_RESP;
               end
            end
            FSWE_S_RDONE: begin
               if (cyc.done) begin
                  rsp_data <= cyc.rdata;
                  st_q     <= FSWE_S_RESP;
               end
            end
            FSWE_S_RESP: begin
               rsp_valid <= 1'b1;
               rsp_fail  <= bad_q;
               cmd_ready <= 1'b1;
               st_q      <= FSWE_S_IDLE;
            end
            default: st_q <= FSWE_S_IDLE;
         endcase
      end
   end

   // First address of the range being worked on
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         first_q <= ADDR_ZERO;
      end else if (st_q == FSWE_S_IDLE && cmd_valid) begin
         first_q <= (cmd_op == FSWE_CMD_SECTOR) ? sector_base(cmd_addr) :
                    (cmd_op == FSWE_CMD_CHIP) ? ADDR_ZERO : cmd_addr;
      end
   end
endmodule

// [verilog/fswe_pkg.sv]
package fswe_pkg;
   // Array geometry
   localparam int ADDR_W        = 16;
   localparam int DATA_W        = 8;
   localparam int SECTOR_COUNT  = 128;
   localparam int SECTOR_BYTES  = 512;
   localparam int SECT_LSB      = 9;
   localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hff;
   localparam logic [ADDR_W-1:0] ADDR_ZERO   = 16'h0000;
   localparam logic [ADDR_W-1:0] ADDR_LAST   = 16'hffff;
   localparam logic [ADDR_W-1:0] SECT_OFS_LAST = 16'h01ff;

   // Clock
   localparam int CLK_PERIOD_NS = 20;

   // Bus timing, in ns
   localparam int T_SETUP_NS    = 50;
   localparam int T_WP_NS       = 150;
   localparam int T_HOLD_NS     = 100;
   localparam int T_READ_NS     = 300;
   localparam int T_VPS_NS      = 2000;
   // Long waits, in us
   localparam int T_WC_US       = 150;
   localparam int T_VPH_US      = 250;
   localparam int T_ABORT_US    = 250;
   localparam int T_ERASE_US    = 500000;
   localparam int T_ER_US       = 500000;

   // Least times round up to whole cycles
   localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WP_CYC    = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CYC  = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_CYC  = (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int VPS_CYC   = (T_VPS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Write passes before verify
   localparam logic [4:0] WRITE_PASSES = 5'h0f;
   localparam logic [4:0] PASS_ZERO    = 5'h00;
   localparam int TMR_W = 32;

   // Commands
   typedef enum logic [2:0] {
      FSWE_CMD_READ   = 3'h0,
      FSWE_CMD_ID     = 3'h1,
      FSWE_CMD_SECTOR = 3'h2,
      FSWE_CMD_CHIP   = 3'h3,
      FSWE_CMD_PROG   = 3'h4
   } fswe_cmd_t;

   // Bus cycle kinds
   typedef enum logic [1:0] {
      FSWE_CYC_READ  = 2'h0,
      FSWE_CYC_WRITE = 2'h1,
      FSWE_CYC_ID    = 2'h2
   } fswe_cyc_t;
endpackage
